// ===== logic/rlc_regs.sv
// Radio link configuration registers with retransmit sequencing.
// Assumes a single-clock register port and a radio core on mclk.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps

module rlc_regs
#(
	parameter int STEP_CYCLES = rlc_pkg::RETRY_STEP_CYC,
	parameter int NUM_PIPES = 6
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_new,
	input wire logic tx_end,
	input wire logic ack_ok,
	input wire logic ack_fail,
	input wire logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] pipe_addr_in,
	output logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] pipe_addr_out,
	output logic [1:0] addr_len_code,
	output logic [6:0] radio_channel,
	output logic carrier_test_enable,
	output logic pll_lock_force,
	output logic [1:0] rate_sel,
	output logic [1:0] tx_power_code,
	output logic retx_req,
	output logic tx_halt
);

	// Step length must be positive; the timer checks its own counter
	if (STEP_CYCLES < 1)
	begin : g_chk
		$error("rlc_regs: STEP_CYCLES must be positive");
	end

	// Write strobes per register
	logic wr_alen;
	logic wr_retr;
	logic wr_ch;
	logic wr_setup;
	logic wr_stat;

	assign wr_alen = reg_wr && reg_addr == rlc_pkg::OFS_ADDR_WIDTH;
	assign wr_retr = reg_wr && reg_addr == rlc_pkg::OFS_RETRANSMIT;
	assign wr_ch = reg_wr && reg_addr == rlc_pkg::OFS_CHANNEL;
	assign wr_setup = reg_wr && reg_addr == rlc_pkg::OFS_RADIO_SETUP;
	assign wr_stat = reg_wr && reg_addr == rlc_pkg::OFS_LINK_STATUS;

	// Configuration fields
	logic [1:0] alen_ff; // Address width code
	logic [1:0] nxt_alen;
	logic [3:0] dly_ff; // Retry delay code
	logic [3:0] nxt_dly;
	logic [3:0] lim_ff; // Retry limit code
	logic [3:0] nxt_lim;
	logic [6:0] ch_ff; // Channel number
	logic [6:0] nxt_ch;
	logic cw_ff; // Continuous carrier
	logic nxt_cw;
	logic rlow_ff; // Low-rate select
	logic nxt_rlow;
	logic pll_ff; // Forced lock
	logic nxt_pll;
	logic rhigh_ff; // High-rate select
	logic nxt_rhigh;
	logic [1:0] pwr_ff; // Output power code
	logic [1:0] nxt_pwr;
	logic [1:0] rate_ff; // Decoded air rate
	logic [1:0] nxt_rate;

	// Configuration next values from register writes
	always_comb
	begin
		nxt_alen = alen_ff;
		nxt_dly = dly_ff;
		nxt_lim = lim_ff;
		nxt_ch = ch_ff;
		nxt_cw = cw_ff;
		nxt_rlow = rlow_ff;
		nxt_pll = pll_ff;
		nxt_rhigh = rhigh_ff;
		nxt_pwr = pwr_ff;
		// Width write; the illegal code is refused
		if (wr_alen && reg_wdata[rlc_pkg::ALEN_MSB:0] != rlc_pkg::ALEN_ILLEGAL)
		begin
			nxt_alen = reg_wdata[rlc_pkg::ALEN_MSB:0];
		end
		// Delay and limit fields
		if (wr_retr)
		begin
			nxt_dly = reg_wdata[rlc_pkg::DLY_MSB:rlc_pkg::DLY_LSB];
			nxt_lim = reg_wdata[rlc_pkg::LIM_MSB:0];
		end
		// Channel; bit 7 is not stored
		if (wr_ch)
		begin
			nxt_ch = reg_wdata[rlc_pkg::CH_MSB:0];
		end
		// Radio setup; bits 6 and 0 are not stored
		if (wr_setup)
		begin
			nxt_cw = reg_wdata[rlc_pkg::CW_BIT];
			nxt_rlow = reg_wdata[rlc_pkg::RLOW_BIT];
			nxt_pll = reg_wdata[rlc_pkg::PLL_BIT];
			nxt_rhigh = reg_wdata[rlc_pkg::RHIGH_BIT];
			nxt_pwr = reg_wdata[rlc_pkg::PWR_MSB:rlc_pkg::PWR_LSB];
		end
		// Low-rate bit overrides high-rate bit
		if (nxt_rlow)
		begin
			nxt_rate = rlc_pkg::RATE_250K;
		end
		else
		begin
			nxt_rate = {1'b0, nxt_rhigh};
		end
	end

	// Configuration registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alen_ff <= rlc_pkg::ALEN_RST;
			dly_ff <= rlc_pkg::DLY_RST;
			lim_ff <= rlc_pkg::LIM_RST;
			ch_ff <= rlc_pkg::CH_RST;
			cw_ff <= 1'b0;
			rlow_ff <= 1'b0;
			pll_ff <= 1'b0;
			rhigh_ff <= rlc_pkg::RHIGH_RST;
			pwr_ff <= rlc_pkg::PWR_RST;
			rate_ff <= {1'b0, rlc_pkg::RHIGH_RST};
		end
		else
		begin
			alen_ff <= nxt_alen;
			dly_ff <= nxt_dly;
			lim_ff <= nxt_lim;
			ch_ff <= nxt_ch;
			cw_ff <= nxt_cw;
			rlow_ff <= nxt_rlow;
			pll_ff <= nxt_pll;
			rhigh_ff <= nxt_rhigh;
			pwr_ff <= nxt_pwr;
			rate_ff <= nxt_rate;
		end
	end

	// Drive the radio from the stored fields
	assign addr_len_code = alen_ff;
	assign radio_channel = ch_ff;
	assign carrier_test_enable = cw_ff;
	assign pll_lock_force = pll_ff;
	assign rate_sel = rate_ff;
	assign tx_power_code = pwr_ff;

	// Pipe addresses trimmed with the common width
	rlc_addr_trim
	#(
		.NUM_PIPES(NUM_PIPES)
	)
	u_trim
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.addr_len_code(alen_ff),
		.addr_in(pipe_addr_in),
		.addr_out(pipe_addr_out)
	);

	// Retransmit sequencer state
	rlc_pkg::rlc_retry_e st_ff; // Sequencer state
	rlc_pkg::rlc_retry_e nxt_st;
	logic [3:0] rcnt_ff; // Retries spent on this packet
	logic [3:0] nxt_rcnt;
	logic [3:0] lost_ff; // Lost packet counter
	logic [3:0] nxt_lost;
	logic exh_ff; // Retry exhausted flag
	logic nxt_exh;
	logic retx_ff; // Retransmit request pulse
	logic nxt_retx;
	logic tmr_start; // Starts the wait timer
	logic tmr_exp; // Wait has elapsed
	logic give_up; // No retries left
	logic exh_set; // Flag set event
	logic lost_inc; // Packet lost event

	assign give_up = lim_ff == 4'h0 || rcnt_ff >= lim_ff;

	// Wait timer, started at an end of transmission seen in idle
	rlc_retry_timer
	#(
		.STEP_CYCLES(STEP_CYCLES)
	)
	u_timer
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.start(tmr_start),
		.delay_code(dly_ff),
		.expired(tmr_exp)
	);

	// Sequencer next state, counters and flag
	always_comb
	begin
		nxt_st = st_ff;
		nxt_rcnt = rcnt_ff;
		nxt_retx = 1'b0;
		tmr_start = 1'b0;
		exh_set = 1'b0;
		lost_inc = 1'b0;
		// New packet restarts the retry count
		if (tx_new)
		begin
			nxt_rcnt = 4'h0;
		end
		unique case (st_ff)
			rlc_pkg::RT_IDLE:
			begin
				// Timing starts at end of transmission
				if (tx_end)
				begin
					tmr_start = 1'b1;
					nxt_st = rlc_pkg::RT_AWAIT;
				end
			end
			rlc_pkg::RT_AWAIT:
			begin
				if (ack_ok)
				begin
					nxt_st = rlc_pkg::RT_IDLE;
				end
				else if (ack_fail && give_up)
				begin
					exh_set = 1'b1;
					lost_inc = 1'b1;
					nxt_st = rlc_pkg::RT_HALT;
				end
				else if (ack_fail && tmr_exp)
				begin
					nxt_retx = 1'b1;
					nxt_rcnt = rcnt_ff + 4'h1;
					nxt_st = rlc_pkg::RT_IDLE;
				end
				else if (ack_fail)
				begin
					nxt_st = rlc_pkg::RT_PEND;
				end
			end
			rlc_pkg::RT_PEND:
			begin
				// Retry once the wait is over
				if (tmr_exp)
				begin
					nxt_retx = 1'b1;
					nxt_rcnt = rcnt_ff + 4'h1;
					nxt_st = rlc_pkg::RT_IDLE;
				end
			end
			rlc_pkg::RT_HALT:
			begin
				// Stay stopped until software clears the flag
				if (!exh_ff)
				begin
					nxt_st = rlc_pkg::RT_IDLE;
				end
			end
			default:
			begin
				nxt_st = rlc_pkg::RT_IDLE;
			end
		endcase
		// Flag: a set in the clearing cycle wins
		nxt_exh = exh_set ||
			(exh_ff && !(wr_stat && reg_wdata[rlc_pkg::EXH_BIT]));
		// Lost counter: channel write clears, increment wins, saturates
		nxt_lost = wr_ch ? 4'h0 : lost_ff;
		if (lost_inc && nxt_lost != rlc_pkg::LOST_MAX)
		begin
			nxt_lost = nxt_lost + 4'h1;
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff <= rlc_pkg::RT_IDLE;
			rcnt_ff <= 4'h0;
			lost_ff <= 4'h0;
			exh_ff <= 1'b0;
			retx_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			rcnt_ff <= nxt_rcnt;
			lost_ff <= nxt_lost;
			exh_ff <= nxt_exh;
			retx_ff <= nxt_retx;
		end
	end

	assign retx_req = retx_ff;
	assign tx_halt = exh_ff;

	// Read data register
	logic [7:0] rdata_ff; // Read data, valid one cycle after strobe
	logic [7:0] nxt_rdata;

	// Read decode; reserved bits and unmapped offsets read zero
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				rlc_pkg::OFS_ADDR_WIDTH:
					nxt_rdata = {6'h00, alen_ff};
				rlc_pkg::OFS_RETRANSMIT:
					nxt_rdata = {dly_ff, lim_ff};
				rlc_pkg::OFS_CHANNEL:
					nxt_rdata = {1'b0, ch_ff};
				rlc_pkg::OFS_RADIO_SETUP:
					nxt_rdata = {cw_ff, 1'b0, rlow_ff, pll_ff, rhigh_ff,
						pwr_ff, 1'b0};
				rlc_pkg::OFS_LINK_STATUS:
					nxt_rdata = {3'h0, exh_ff, 4'h0};
				rlc_pkg::OFS_OBSERVE:
					nxt_rdata = {lost_ff, rcnt_ff};
				default:
					nxt_rdata = 8'h00;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;

endmodule // rlc_regs

// ===== logic/rlc_pkg.sv
// Constants for the radio link configuration register bank.
// Assumes an 8-bit register port and a 100 MHz system clock.
package rlc_pkg;

	// Register offsets
	localparam logic [7:0] OFS_ADDR_WIDTH = 8'h03;
	localparam logic [7:0] OFS_RETRANSMIT = 8'h04;
	localparam logic [7:0] OFS_CHANNEL = 8'h05;
	localparam logic [7:0] OFS_RADIO_SETUP = 8'h06;
	localparam logic [7:0] OFS_LINK_STATUS = 8'h07;
	localparam logic [7:0] OFS_OBSERVE = 8'h08;

	// Field positions
	localparam int ALEN_MSB = 1;
	localparam int DLY_MSB = 7;
	localparam int DLY_LSB = 4;
	localparam int LIM_MSB = 3;
	localparam int CH_MSB = 6;
	localparam int CW_BIT = 7;
	localparam int RLOW_BIT = 5;
	localparam int PLL_BIT = 4;
	localparam int RHIGH_BIT = 3;
	localparam int PWR_MSB = 2;
	localparam int PWR_LSB = 1;
	localparam int EXH_BIT = 4;
	localparam int LOST_MSB = 7;
	localparam int LOST_LSB = 4;

	// Reset values, width codes and lost counter limit
	localparam logic [1:0] ALEN_RST = 2'h3;
	localparam logic [1:0] ALEN_ILLEGAL = 2'h0;
	localparam logic [1:0] ALEN_3B = 2'h1;
	localparam logic [1:0] ALEN_4B = 2'h2;
	localparam logic [3:0] DLY_RST = 4'h0;
	localparam logic [3:0] LIM_RST = 4'h3;
	localparam logic [6:0] CH_RST = 7'h02;
	localparam logic RHIGH_RST = 1'b1;
	localparam logic [1:0] PWR_RST = 2'h3;
	localparam logic [3:0] LOST_MAX = 4'hF;

	// Air rate codes driven to the modem
	localparam logic [1:0] RATE_1M = 2'h0;
	localparam logic [1:0] RATE_250K = 2'h2;

	// Timing
	localparam int CLK_MHZ = 100;
	localparam int RETRY_STEP_US = 250;
	localparam int RETRY_STEP_CYC = RETRY_STEP_US * CLK_MHZ;
	localparam int DLY_CODES = 16;

	// Address geometry
	localparam int ADDR_MAX_W = 40;

	// Retransmit sequencer states
	typedef enum logic [3:0]
	{
		RT_IDLE = 4'h1,
		RT_AWAIT = 4'h2,
		RT_PEND = 4'h4,
		RT_HALT = 4'h8
	} rlc_retry_e;

endpackage

// ===== logic/rlc_retry_timer.sv
// Retransmit wait timer: counts (code + 1) delay steps after a start.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module rlc_retry_timer
#(
	parameter int STEP_CYCLES = rlc_pkg::RETRY_STEP_CYC,
	parameter int CNT_W = 20
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] delay_code,
	output logic expired
);

	// Longest wait must fit the counter
	if (STEP_CYCLES < 1 ||
		STEP_CYCLES * rlc_pkg::DLY_CODES > (2 ** CNT_W))
	begin : g_chk
		$error("rlc_retry_timer: counter too narrow for step");
	end

	logic [CNT_W-1:0] cnt_ff; // Cycles left
	logic [CNT_W-1:0] nxt_cnt;
	logic run_ff; // Timer active
	logic nxt_run;
	logic exp_ff; // Wait elapsed, held until next start
	logic nxt_exp;

	assign expired = exp_ff;

	// Load on start, count down, flag at zero
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_exp = exp_ff;
		if (start)
		begin
			nxt_cnt = CNT_W'((int'(delay_code) + 1) * STEP_CYCLES - 1);
			nxt_run = 1'b1;
			nxt_exp = 1'b0;
		end
		else if (run_ff && cnt_ff == '0)
		begin
			nxt_run = 1'b0;
			nxt_exp = 1'b1;
		end
		else if (run_ff)
		begin
			nxt_cnt = cnt_ff - CNT_W'(1);
		end
	end

	// State registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			exp_ff <= nxt_exp;
		end
	end

endmodule // rlc_retry_timer

// ===== logic/rlc_addr_trim.sv
// Trims every pipe address to the configured width, low bytes kept.
// Assumes addresses are held elsewhere, least significant byte in [7:0].
`timescale 1ns/100ps
module rlc_addr_trim
#(
	parameter int NUM_PIPES = 6
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] addr_len_code,
	input wire logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] addr_in,
	output logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] addr_out
);

	localparam int AW = rlc_pkg::ADDR_MAX_W;

	if (NUM_PIPES < 1)
	begin : g_chk
		$error("rlc_addr_trim: need at least one pipe");
	end

	// Byte mask for a width code; the illegal code keeps all bytes
	function automatic logic [AW-1:0] keep_mask(input logic [1:0] code);
		unique case (code)
			rlc_pkg::ALEN_3B: keep_mask = {16'h0000, 24'hFFFFFF};
			rlc_pkg::ALEN_4B: keep_mask = {8'h00, 32'hFFFFFFFF};
			default: keep_mask = {AW{1'b1}};
		endcase
	endfunction

	logic [AW-1:0] mask; // One mask shared by all pipes
	assign mask = keep_mask(addr_len_code);

	// One registered trim stage per pipe
	for (genvar p = 0; p < NUM_PIPES; p++)
	begin : g_pipe
		logic [AW-1:0] trim_ff;
		logic [AW-1:0] nxt_trim;
		// Upper bytes dropped when width is short
		always_comb
		begin
			nxt_trim = addr_in[p*AW +: AW] & mask;
		end
		// Trimmed address register
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
				trim_ff <= '0;
			else
				trim_ff <= nxt_trim;
		end
		assign addr_out[p*AW +: AW] = trim_ff;
	end

endmodule // rlc_addr_trim

// ===== verif/rlc_regs_sva.sv
// Checker for the radio link configuration register bank.
// Sees only the ports of rlc_regs; bound to it at the foot.
`timescale 1ns/100ps
module rlc_regs_sva
#(
	parameter int STEP_CYCLES = 2,
	parameter int NUM_PIPES = 6
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] pipe_addr_in,
	input wire logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] pipe_addr_out,
	input wire logic [1:0] addr_len_code,
	input wire logic [6:0] radio_channel,
	input wire logic carrier_test_enable,
	input wire logic pll_lock_force,
	input wire logic [1:0] rate_sel,
	input wire logic [1:0] tx_power_code,
	input wire logic retx_req,
	input wire logic tx_halt
);
	logic [7:0] wd_q; // Write data of the last edge
	logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] in_q; // Last addresses
	logic [1:0] len_q; // Width code of the last edge
	logic [NUM_PIPES*rlc_pkg::ADDR_MAX_W-1:0] exp_trim; // Expected out
	logic wr_ch; // Write to the channel register
	logic wr_set; // Write to the radio setup register
	logic clr_flag; // Write of one to the exhausted flag

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Keeps inputs for comparison one edge later
	always_ff @(posedge mclk)
	begin
		wd_q <= reg_wdata;
		in_q <= pipe_addr_in;
		len_q <= addr_len_code;
	end

	// Clears the bytes beyond the configured width in every pipe
	always_comb
	begin
		exp_trim = in_q;
		for (int p = 0; p < NUM_PIPES; p++)
		begin
			if (len_q == rlc_pkg::ALEN_3B)
				exp_trim[p*40+24 +: 16] = '0;
			else if (len_q == rlc_pkg::ALEN_4B)
				exp_trim[p*40+32 +: 8] = '0;
		end
	end

	assign wr_ch = reg_wr && reg_addr == rlc_pkg::OFS_CHANNEL;
	assign wr_set = reg_wr && reg_addr == rlc_pkg::OFS_RADIO_SETUP;
	assign clr_flag = reg_wr && reg_addr == rlc_pkg::OFS_LINK_STATUS
		&& reg_wdata[4];

	a_width_code: assert property (
		reg_wr && reg_addr == rlc_pkg::OFS_ADDR_WIDTH |=> addr_len_code ==
		((wd_q[1:0] == 2'h0) ? $past(addr_len_code) : wd_q[1:0]))
		else $error("width code not kept");
	a_chan_write: assert property (
		wr_ch |=> radio_channel == wd_q[6:0])
		else $error("channel not stored");
	a_chan_read: assert property (
		reg_rd && reg_addr == rlc_pkg::OFS_CHANNEL
		|=> reg_rdata == {1'b0, $past(radio_channel)})
		else $error("channel read wrong");
	a_setup_bits: assert property (
		wr_set |=> carrier_test_enable == wd_q[7]
		&& pll_lock_force == wd_q[4] && tx_power_code == wd_q[2:1])
		else $error("setup bits not stored");
	a_rate_low: assert property (
		wr_set |=> rate_sel == (wd_q[5] ? 2'h2 : {1'b0, wd_q[3]}))
		else $error("air rate wrong");
	a_addr_trim: assert property (
		$past(rst_n) |-> pipe_addr_out == exp_trim)
		else $error("address trim wrong");
	a_halt_hold: assert property (
		tx_halt && !clr_flag |=> tx_halt)
		else $error("halt dropped");
	a_halt_clear: assert property (
		tx_halt && clr_flag |=> !tx_halt)
		else $error("halt not cleared");
	a_retx_single: assert property (
		retx_req |=> !retx_req)
		else $error("retransmit request too long");
	a_read_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
endmodule // rlc_regs_sva

bind rlc_regs rlc_regs_sva
#(
	.STEP_CYCLES(STEP_CYCLES),
	.NUM_PIPES(NUM_PIPES)
)
u_rlc_regs_sva
(
	.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pipe_addr_in(pipe_addr_in),
	.pipe_addr_out(pipe_addr_out), .addr_len_code(addr_len_code),
	.radio_channel(radio_channel),
	.carrier_test_enable(carrier_test_enable),
	.pll_lock_force(pll_lock_force), .rate_sel(rate_sel),
	.tx_power_code(tx_power_code), .retx_req(retx_req),
	.tx_halt(tx_halt)
);

// ===== verif/radio_link_config_regs_test.sv
// Self-checking bench for the radio link configuration registers.
// Assumes rlc_regs with a short retry step, all on mclk.
`timescale 1ns/100ps
module radio_link_config_regs_test;
	localparam int STEP = 2; // Short retry step
	localparam int AW = 6 * rlc_pkg::ADDR_MAX_W; // Address bus width
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tx_new = 1'b0;
	logic tx_end = 1'b0;
	logic ack_ok = 1'b0;
	logic ack_fail = 1'b0;
	logic [AW-1:0] pipe_in = '0; // Random pipe addresses
	logic [7:0] pr = 8'h18; // Address stream state
	logic [7:0] rnd = 8'h18; // Driver random state
	logic [7:0] d; // Setup value under test
	logic [1:0] len = 2'h3; // Width code expected
	logic [7:0] reg_rdata;
	logic [1:0] rate_sel;
	logic retx_req;
	logic tx_halt;
	logic rd_pend = 1'b0; // Read taken at the last edge
	logic [7:0] exp_q[$]; // Expected read data
	logic [1:0] codes[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
	logic [3:0] dl[2] = '{4'h1, 4'hF};
	int mismatches = 0;
	int comparisons = 0;

	rlc_regs
	#(
		.STEP_CYCLES(STEP),
		.NUM_PIPES(6)
	)
	u_rlc_regs
	(
		.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_new(tx_new), .tx_end(tx_end),
		.ack_ok(ack_ok), .ack_fail(ack_fail), .pipe_addr_in(pipe_in),
		.pipe_addr_out(), .addr_len_code(), .radio_channel(),
		.carrier_test_enable(), .pll_lock_force(), .rate_sel(rate_sel),
		.tx_power_code(), .retx_req(retx_req), .tx_halt(tx_halt)
	);

	// Clock of 10 ns
	initial
	begin
		forever #5 mclk = ~mclk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Register write, one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Register read; expectation noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	task automatic newpkt();
		@(posedge mclk);
		tx_new <= 1'b1;
		@(posedge mclk);
		tx_new <= 1'b0;
	endtask

	// Transmission end followed by an acknowledge outcome
	task automatic ack(input logic ok);
		@(posedge mclk);
		tx_end <= 1'b1;
		@(posedge mclk);
		tx_end <= 1'b0;
		ack_ok <= ok;
		ack_fail <= !ok;
		@(posedge mclk);
		ack_ok <= 1'b0;
		ack_fail <= 1'b0;
	endtask

	// Failed acknowledge, then cycles from transmission end to retry
	task automatic retry(input logic [7:0] e);
		int n;
		n = 1;
		ack(1'b0);
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (retx_req !== 1'b1 && n < 300);
		check(8'(n), e);
		if (n >= 300)
		begin
			mismatches++;
			give_verdict();
		end
	endtask

	// Random pipe addresses, one new byte each cycle
	always @(posedge mclk)
	begin
		pr <= lfsr(pr);
		pipe_in <= {pipe_in[AW-9:0], pr};
	end

	// Notes a read taken at this edge
	always @(posedge mclk)
		rd_pend <= reg_rd;

	// Compares read data with the oldest expectation
	always @(negedge mclk)
		if (rd_pend)
			check(reg_rdata, exp_q.pop_front());

	initial
	begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		// Reset values and an unmapped offset
		rd(rlc_pkg::OFS_ADDR_WIDTH, 8'h03);
		rd(rlc_pkg::OFS_RETRANSMIT, 8'h03);
		rd(rlc_pkg::OFS_CHANNEL, 8'h02);
		rd(rlc_pkg::OFS_RADIO_SETUP, 8'h0E);
		check({6'h00, rate_sel}, 8'h01);
		wr(8'h09, 8'hFF);
		rd(8'h09, 8'h00);
		// Width codes, reserved bits zero; illegal code is refused
		foreach (codes[i])
		begin
			wr(rlc_pkg::OFS_ADDR_WIDTH, {6'h00, codes[i]});
			if (codes[i] != 2'h0)
				len = codes[i];
			rd(rlc_pkg::OFS_ADDR_WIDTH, {6'h00, len});
		end
		// Every rate and power code, random bits 7, 4 and 0, bit 6 zero
		for (int i = 0; i < 16; i++)
		begin
			rnd = lfsr(rnd);
			d = {rnd[7], 1'b0, i[1], rnd[4], i[0], i[3:2], rnd[0]};
			wr(rlc_pkg::OFS_RADIO_SETUP, d);
			@(negedge mclk);
			check({6'h00, rate_sel}, d[5] ? 8'h02 : {7'h00, d[3]});
			rd(rlc_pkg::OFS_RADIO_SETUP, d & 8'hBE);
			wr(rlc_pkg::OFS_CHANNEL, rnd & 8'h7F);
			rd(rlc_pkg::OFS_CHANNEL, rnd & 8'h7F);
			wr(rlc_pkg::OFS_RETRANSMIT, rnd ^ 8'h5A);
			rd(rlc_pkg::OFS_RETRANSMIT, rnd ^ 8'h5A);
		end
		// A short (code 1) and the longest (code 15) retry wait
		foreach (dl[i])
		begin
			wr(rlc_pkg::OFS_RETRANSMIT, {dl[i], 4'hF});
			newpkt();
			retry(8'((dl[i] + 1) * STEP + 2));
		end
		// Limit of one: retry, then halt; ends ignored while halted
		wr(rlc_pkg::OFS_RETRANSMIT, 8'h01);
		newpkt();
		retry(8'(STEP + 2));
		ack(1'b0);
		ack(1'b0);
		@(negedge mclk);
		check({7'h00, tx_halt}, 8'h01);
		rd(rlc_pkg::OFS_OBSERVE, 8'h11);
		wr(rlc_pkg::OFS_LINK_STATUS, 8'h10);
		@(negedge mclk);
		check({7'h00, tx_halt}, 8'h00);
		wr(rlc_pkg::OFS_CHANNEL, 8'h2A);
		rd(rlc_pkg::OFS_OBSERVE, 8'h01);
		// Limit zero: success passes, failure halts at once
		wr(rlc_pkg::OFS_RETRANSMIT, 8'h00);
		newpkt();
		ack(1'b1);
		ack(1'b0);
		rd(rlc_pkg::OFS_OBSERVE, 8'h10);
		wr(rlc_pkg::OFS_LINK_STATUS, 8'h10);
		repeat (3) @(posedge mclk);
		give_verdict();
	end
endmodule // radio_link_config_regs_test
